// *** rtl/shift_deny_consts.svh ***
// Purpose: constants for the shift request denied flag block
// Assumes: 100 MHz clock
// Notes:   offsets are byte addresses on the register bus
`ifndef SHIFT_DENY_CONSTS_SVH
`define SHIFT_DENY_CONSTS_SVH
`define CLK_FREQ_HZ       100000000
`define TICK_MS_NUM       1
`define TICK_CYCLES       (`CLK_FREQ_HZ / 1000 * `TICK_MS_NUM)
`define DENY_TIMEOUT_MS   500
`define REG_CTRL          8'h00
`define REG_GEAR          8'h04
`define REG_ALLOW         8'h08
`define REG_STATUS        8'h0C
`define CTRL_HAS_TC       0
`define CTRL_TAP_SUPPORT  1
`define CTRL_TAP_MODE     2
`define CTRL_RESET        32'h0000_0000
`define GEAR_RESET        32'h0000_0006
`define ALLOW_RESET       32'h0000_00FF
`define STAT_DENIED_BIT   0
`define STAT_MODE_BIT     1
`define STAT_GEAR_LSB     8
`define STAT_TARGET_LSB   16
`define STAT_COUNT_LSB    24
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

// *** rtl/shift_deny_pkg.sv ***
// Purpose: types for the shift request denied flag block
// Assumes: nothing
// Notes:   constants live in shift_deny_consts.svh
package shift_deny_pkg;
   typedef enum logic [1:0] {WR_IDLE, WR_RESP} wrState_t;
   typedef enum logic [1:0] {RD_IDLE, RD_RESP} rdState_t;
   typedef logic [3:0] gear_t;
endpackage

// *** rtl/pin_sync.sv ***
// Purpose: three flop synchroniser with agreement filter for a pin
// Assumes: input is asynchronous to clock
// Notes:   output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic pinIn,
   output var  logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } syncState_t;
   syncState_t st;
   syncState_t next_st;

   always_comb begin
      next_st     = st;
      next_st.s1  = pinIn;
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
      if (srst) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clock) begin
      st <= next_st;
   end

   assign level = st.lvl;
endmodule // pin_sync
`default_nettype wire

// *** rtl/shift_deny_flag.sv ***
// Purpose: driver shift request denied indication with AXI4-Lite registers
// Assumes: gear limits and permission come from the transmission_controller logic
// Notes:   flag latches on refusal, clears on allowed request, mode exit or timeout
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "shift_deny_consts.svh"
module shift_deny_flag
   import shift_deny_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int TIMEOUT_MS  = `DENY_TIMEOUT_MS
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        tapUpMsg,
   input  wire logic        tapDownMsg,
   input  wire logic        tapUpPin,
   input  wire logic        tapDownPin,
   input  wire logic        tapModeActive,
   input  wire logic        limitOverspeed,
   input  wire logic        limitLugging,
   input  wire logic        limitCooling,
   input  wire logic        limitLube,
   input  wire logic        limitOther,
   input  wire gear_t       currentGear,
   output var  logic        deniedValid,
   output var  logic        deniedOn,
   output var  logic        targetGearChange,
   output var  gear_t       targetGear
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int MW = $clog2(TIMEOUT_MS + 2);

   typedef struct packed {
      wrState_t         wr;
      logic             awHeld;
      logic [7:0]       awAddr;
      logic             wHeld;
      logic [31:0]      wData;
      logic [3:0]       wStrb;
      logic [1:0]       bResp;
      rdState_t         rd;
      logic [31:0]      rData;
      logic [1:0]       rResp;
      logic [31:0]      ctrl;
      logic [31:0]      gearCfg;
      logic [31:0]      allowMask;
      logic             upPinLast;
      logic             downPinLast;
      logic             denied;
      logic             timing;
      logic [TW-1:0]    tickCnt;
      logic [MW-1:0]    msCnt;
      gear_t            target;
      logic             targetPulse;
      logic [7:0]       denyCount;
   } state_t;

   state_t st;
   state_t next_st;
   logic   upPinLvl;
   logic   downPinLvl;

   pin_sync upSync (
      .clock (clock),
      .srst  (srst),
      .pinIn (tapUpPin),
      .level (upPinLvl)
   );

   pin_sync downSync (
      .clock (clock),
      .srst  (srst),
      .pinIn (tapDownPin),
      .level (downPinLvl)
   );

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic  hasTc;
   logic  tapSupport;
   logic  tapMode;
   gear_t topGear;
   logic  upReq;
   logic  downReq;
   logic  anyReq;
   logic  limited;
   logic  atEdge;
   gear_t wanted;
   logic  wantedOk;
   logic [31:0] statusWord;

   always_comb begin
      hasTc      = st.ctrl[`CTRL_HAS_TC];
      tapSupport = st.ctrl[`CTRL_TAP_SUPPORT];
      // tap mode is active only if software and the mode input agree
      tapMode    = st.ctrl[`CTRL_TAP_MODE] & tapModeActive;
      topGear    = st.gearCfg[3:0];
      // message and switch edges are driver requests only
      upReq      = tapUpMsg | (upPinLvl & ~st.upPinLast);
      downReq    = tapDownMsg | (downPinLvl & ~st.downPinLast);
      // simultaneous up and down cancels out and is not a request
      anyReq     = (upReq ^ downReq) & tapMode & tapSupport;
      limited    = limitOverspeed
                 | limitLugging
                 | limitCooling
                 | limitLube
                 | limitOther;
      atEdge     = (downReq && currentGear <= 4'h1) || (upReq && currentGear >= topGear);
      wanted     = upReq ? gear_t'(currentGear + 4'h1) : gear_t'(currentGear - 4'h1);
      wantedOk   = ~limited & st.allowMask[wanted];
   end

   // status word built field by field, unused bits read as zero
   always_comb begin
      statusWord                        = '0;
      statusWord[`STAT_DENIED_BIT]      = st.denied;
      statusWord[`STAT_MODE_BIT]        = tapMode;
      statusWord[`STAT_GEAR_LSB +: 4]   = currentGear;
      statusWord[`STAT_TARGET_LSB +: 4] = st.target;
      statusWord[`STAT_COUNT_LSB +: 8]  = st.denyCount;
   end

   always_comb begin
      next_st             = st;
      next_st.targetPulse = 1'b0;
      next_st.upPinLast   = upPinLvl;
      next_st.downPinLast = downPinLvl;

      // ---- millisecond tick and timeout
      if (st.timing) begin
         if (st.tickCnt >= TW'(TICK_CYCLES - 1)) begin
            next_st.tickCnt = '0;
            next_st.msCnt   = st.msCnt + MW'(1);
         end else begin
            next_st.tickCnt = st.tickCnt + TW'(1);
         end
      end
      // strictly more than the timeout must elapse
      if (st.denied && st.msCnt > MW'(TIMEOUT_MS)) begin
         next_st.denied = 1'b0;
         next_st.timing = 1'b0;
      end

      // ---- request evaluation
      if (anyReq) begin
         if (atEdge) begin
            next_st.denied = 1'b0;
            next_st.timing = 1'b0;
         end else if (wantedOk) begin
            next_st.denied      = 1'b0;
            next_st.timing      = 1'b0;
            next_st.target      = wanted;
            next_st.targetPulse = 1'b1;
         end else begin
            next_st.denied    = 1'b1;
            next_st.timing    = 1'b1;
            next_st.tickCnt   = '0;
            next_st.msCnt     = '0;
            next_st.denyCount = st.denyCount + 8'h01;
         end
      end
      if (!tapMode || !tapSupport) begin
         next_st.denied = 1'b0;
         next_st.timing = 1'b0;
      end

      // ---- AXI write channel, address and data in either order
      if (s_axi_awvalid && !st.awHeld && st.wr == WR_IDLE) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.wHeld && st.wr == WR_IDLE) begin
         next_st.wHeld = 1'b1;
         next_st.wData = s_axi_wdata;
         next_st.wStrb = s_axi_wstrb;
      end
      case (st.wr)
         WR_IDLE: begin
            if (st.awHeld && st.wHeld) begin
               next_st.bResp = `RESP_OKAY;
               case (st.awAddr)
                  `REG_CTRL:  next_st.ctrl = mergeBytes(st.ctrl, st.wData, st.wStrb);
                  `REG_GEAR:  next_st.gearCfg = mergeBytes(st.gearCfg, st.wData, st.wStrb);
                  `REG_ALLOW: next_st.allowMask = mergeBytes(st.allowMask, st.wData, st.wStrb);
                  `REG_STATUS: next_st.bResp = `RESP_OKAY;
                  default:    next_st.bResp = `RESP_SLVERR;
               endcase
               next_st.awHeld = 1'b0;
               next_st.wHeld  = 1'b0;
               next_st.wr     = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_st.wr = WR_IDLE;
            end
         end
         default: next_st.wr = WR_IDLE;
      endcase

      // ---- AXI read channel
      case (st.rd)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               next_st.rResp = `RESP_OKAY;
               case (s_axi_araddr)
                  `REG_CTRL:   next_st.rData = {29'h0, st.ctrl[2:0]};
                  `REG_GEAR:   next_st.rData = {28'h0, st.gearCfg[3:0]};
                  `REG_ALLOW:  next_st.rData = {16'h0, st.allowMask[15:0]};
                  `REG_STATUS: next_st.rData = statusWord;
                  default: begin
                     next_st.rData = '0;
                     next_st.rResp = `RESP_SLVERR;
                  end
               endcase
               next_st.rd = RD_RESP;
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               next_st.rd = RD_IDLE;
            end
         end
         default: next_st.rd = RD_IDLE;
      endcase

      if (srst) begin
         next_st           = '0;
         next_st.ctrl      = `CTRL_RESET;
         next_st.gearCfg   = `GEAR_RESET;
         next_st.allowMask = `ALLOW_RESET;
         next_st.target    = 4'h1;
         next_st.wr        = WR_IDLE;
         next_st.rd        = RD_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      st <= next_st;
   end

   assign s_axi_awready    = (st.wr == WR_IDLE) & ~st.awHeld;
   assign s_axi_wready     = (st.wr == WR_IDLE) & ~st.wHeld;
   assign s_axi_bvalid     = (st.wr == WR_RESP);
   assign s_axi_bresp      = st.bResp;
   assign s_axi_arready    = (st.rd == RD_IDLE);
   assign s_axi_rvalid     = (st.rd == RD_RESP);
   assign s_axi_rdata      = st.rData;
   assign s_axi_rresp      = st.rResp;
   assign deniedValid      = st.ctrl[`CTRL_HAS_TC];
   assign deniedOn         = st.denied & st.ctrl[`CTRL_HAS_TC];
   assign targetGearChange = st.targetPulse;
   assign targetGear       = st.target;
endmodule // shift_deny_flag
`default_nettype wire

// *** sim/shift_deny_flag_assertions.sv ***
// Purpose: port assertions for shift_deny_flag
// Assumes: tick and timeout parameters match the bound instance
// Notes:   bind statement at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module shift_deny_checker
   import shift_deny_pkg::*;
#(
   parameter int TICK_CYCLES = 10,
   parameter int TIMEOUT_MS  = 5
) (
   input wire logic  clock,
   input wire logic  srst,
   input wire logic  s_axi_awready,
   input wire logic  s_axi_wready,
   input wire logic  s_axi_bvalid,
   input wire logic  s_axi_arvalid,
   input wire logic  s_axi_arready,
   input wire logic  s_axi_rvalid,
   input wire logic  tapUpMsg,
   input wire logic  tapDownMsg,
   input wire logic  tapUpPin,
   input wire logic  tapDownPin,
   input wire logic  tapModeActive,
   input wire gear_t currentGear,
   input wire logic  deniedValid,
   input wire logic  deniedOn,
   input wire logic  targetGearChange,
   input wire gear_t targetGear
);
   int unsigned held;

   // two ticks over the timeout: one for the strict compare, one spare, as the tick count restarts at refusal
   always_ff @(posedge clock) begin
      if (srst || !deniedOn || tapUpMsg || tapDownMsg || tapUpPin || tapDownPin)
         held <= 0;
      else
         held <= held + 1;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_flag_needs_tc: assert property (deniedOn |-> deniedValid)
      else $error("denied shown while not transmitted");
   a_mode_exit_clear: assert property (!tapModeActive |=> !deniedOn)
      else $error("denied kept after tap mode ended");
   a_timeout_clear: assert property (held <= TICK_CYCLES * (TIMEOUT_MS + 2))
      else $error("denied kept past timeout");
   a_deny_has_cause: assert property ($rose(deniedOn) |->
      $past(tapUpMsg || tapDownMsg) || tapUpPin || tapDownPin)
      else $error("denied raised without a driver request");
   a_allowed_clears: assert property (targetGearChange |-> !deniedOn)
      else $error("allowed change left denied set");
   a_target_step: assert property (targetGearChange |-> targetGear ==
      $past(currentGear) + 4'h1 || targetGear == $past(currentGear) - 4'h1)
      else $error("target gear not one step away");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // shift_deny_checker

bind shift_deny_flag shift_deny_checker #(
   .TICK_CYCLES(TICK_CYCLES),
   .TIMEOUT_MS (TIMEOUT_MS)
) chk (.*);
`default_nettype wire

// *** sim/body_feedback.sv ***
// Purpose: body controller that turns the denied flag into driver feedback
// Assumes: shift control active is the tap mode level
// Notes:   one cycle of delay, well inside the actuation budget
`timescale 1ns/100ps
`default_nettype none
module body_feedback (
   input  wire logic deniedValid,
   input  wire logic deniedOn,
   input  wire logic shiftActive,
   input  wire logic clock,
   output var  logic feedbackOn
);
   always_ff @(posedge clock) begin
      feedbackOn <= deniedValid && deniedOn && shiftActive;
   end
endmodule // body_feedback
`default_nettype wire

// *** sim/tb_shift_deny_flag.sv ***
// Purpose: self-checking bench for shift_deny_flag
// Assumes: tick shortened to 10 cycles, timeout to 5 ticks
// Notes:   register reads are checked by a monitor through a queue
`timescale 1ns/100ps
`default_nettype none
`include "shift_deny_consts.svh"
module tb_shift_deny_flag
   import shift_deny_pkg::*;
;
   logic        clock = 0, srst = 1;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, dValid, dOn, tgc, fb;
   logic [1:0]  bresp, rresp;
   logic        upMsg = 0, downMsg = 0, upPin = 0, downPin = 0, modeOn = 0;
   logic [4:0]  lim = '0;
   gear_t       gear = 4'h3, tgt;
   int          miscompares = 0, check_count = 0, t = 0;
   logic [33:0] expQ[$];
   int          pulses = 0;

   shift_deny_flag #(.TICK_CYCLES(10), .TIMEOUT_MS(5)) uut (
      .clock(clock), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tapUpMsg(upMsg), .tapDownMsg(downMsg), .tapUpPin(upPin), .tapDownPin(downPin),
      .tapModeActive(modeOn), .limitOverspeed(lim[0]), .limitLugging(lim[1]),
      .limitCooling(lim[2]), .limitLube(lim[3]), .limitOther(lim[4]),
      .currentGear(gear), .deniedValid(dValid), .deniedOn(dOn),
      .targetGearChange(tgc), .targetGear(tgt));
   body_feedback body (.deniedValid(dValid), .deniedOn(dOn), .shiftActive(modeOn),
      .clock(clock), .feedbackOn(fb));

   always #5 clock = ~clock;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic guard(input int n);
      if (n >= 50) begin
         miscompares++;
         finish_test();
      end
   endtask

   task automatic next_t();
      t++;
      $display("test %0d done", t);
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!(bvalid && bready) && n < 50);
      bready <= 0;
      guard(n);
      chk(bresp, er);
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      expQ.push_back({`RESP_OKAY, d});
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arready) arvalid <= 0;
      end while (!(rvalid && rready) && n < 50);
      rready <= 0;
      guard(n);
   endtask

   always @(posedge clock) begin
      if (rvalid && rready && expQ.size() > 0) chk({rresp, rdata}, expQ.pop_front());
   end

   // every allowed change must show as exactly one target pulse
   always @(posedge clock) begin
      if (tgc) pulses <= pulses + 1;
   end

   // request by message pulse or by switch edge, then look at the flag
   task automatic tap(input logic up, input logic pin, input logic exp);
      @(posedge clock);
      if (pin) {upPin, downPin} <= {up, !up};
      else {upMsg, downMsg} <= {up, !up};
      repeat (pin ? 12 : 1) @(posedge clock);
      {upMsg, downMsg, upPin, downPin} <= 4'h0;
      repeat (pin ? 8 : 2) @(posedge clock);
      #1 chk(dOn, exp);
      @(posedge clock);
   endtask

   initial begin
      void'($urandom(32'h4f6b));
      repeat (20) @(posedge clock);
      srst <= 0;
      axr(`REG_CTRL, 32'h0000_0000);
      axr(`REG_GEAR, 32'h0000_0006);
      axr(`REG_ALLOW, 32'h0000_00FF);
      axw(`REG_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
      axr(`REG_STATUS, 32'h0001_0300);
      axw(8'h10, 32'h0000_0000, `RESP_SLVERR);
      chk(dValid, 1'b0);
      next_t();
      modeOn <= 1;
      axw(`REG_CTRL, 32'h0000_0007, `RESP_OKAY);
      chk(dValid, 1'b1);
      tap(1, 0, 1'b0);
      chk(tgt, 4'h4);
      for (int i = 0; i < 5; i++) begin
         lim <= 5'h01 << i;
         tap(1, 0, 1'b1);
         chk(fb, 1'b1);
         lim <= '0;
         tap(0, 0, 1'b0);
      end
      next_t();
      gear <= 4'h2 + gear_t'($urandom_range(3));
      lim <= 5'h01 << $urandom_range(4);
      tap(1, 0, 1'b1);
      repeat (50) @(posedge clock);
      #1 chk(dOn, 1'b1);
      repeat (30) @(posedge clock);
      #1 chk(dOn, 1'b0);
      tap(1, 0, 1'b1);
      modeOn <= 0;
      repeat (3) @(posedge clock);
      #1 chk(dOn, 1'b0);
      @(posedge clock);
      modeOn <= 1;
      next_t();
      tap(1, 0, 1'b1);
      gear <= 4'h1;
      tap(0, 0, 1'b0);
      tap(1, 0, 1'b1);
      gear <= 4'h6;
      tap(1, 0, 1'b0);
      next_t();
      lim <= '0;
      gear <= 4'h3;
      axw(`REG_ALLOW, 32'h0000_00EF, `RESP_OKAY);
      tap(1, 1, 1'b1);
      {upMsg, downMsg} <= 2'b11;
      @(posedge clock);
      {upMsg, downMsg} <= 2'b00;
      repeat (2) @(posedge clock);
      #1 chk(dOn, 1'b1);
      @(posedge clock);
      tap(0, 1, 1'b0);
      axw(`REG_CTRL, 32'h0000_0005, `RESP_OKAY);
      tap(1, 0, 1'b0);
      axw(`REG_CTRL, 32'h0000_0006, `RESP_OKAY);
      tap(1, 0, 1'b0);
      chk(dValid, 1'b0);
      chk(pulses, 7);
      next_t();
      finish_test();
   end
endmodule // tb_shift_deny_flag
`default_nettype wire
